// File: hdl/fcs_power_corr_map.vh
// constants for the power correction and status block
`ifndef FCS_POWER_CORR_MAP_VH
`define FCS_POWER_CORR_MAP_VH
// table geometry
`define FCS_TBL_DEPTH 80
`define FCS_TBL_LAST 7'h4f
// frequency scale codes and multipliers
`define FCS_SCALE_HZ 2'h0
`define FCS_SCALE_KHZ 2'h1
`define FCS_SCALE_MHZ 2'h2
`define FCS_MULT_HZ 30'h0000_0001
`define FCS_MULT_KHZ 30'h0000_03e8
`define FCS_MULT_MHZ 30'h000f_4240
`define FCS_MULT_GHZ 30'h3b9a_ca00
// factor in hundredths of a percent, 100 percent
`define FCS_UNITY_GAIN 16'h2710
`define FCS_UNITY_GAIN_W 14'h2710
// averaging
`define FCS_AVG_MIN 11'h001
`define FCS_AVG_MAX 11'h400
`define FCS_AUTO_CNT_LO 11'h400
`define FCS_AUTO_CNT_MID 11'h080
`define FCS_AUTO_CNT_HI 11'h010
`define FCS_AUTO_THR_LO 32'h0000_1000
`define FCS_AUTO_THR_MID 32'h0010_0000
// range switch level
`define FCS_RANGE_THR 32'h0100_0000
// zeroing sample count and its log2
`define FCS_ZERO_SAMPLES 5'h10
`define FCS_ZERO_SHIFT 4
// divider
`define FCS_DIV_STEPS 7'h40
// decibel mantissa table, 10^(r/10) in q14
`define FCS_DB_FRAC 14
`define FCS_DB_M0 18'h04000
`define FCS_DB_M1 18'h05092
`define FCS_DB_M2 18'h0656f
`define FCS_DB_M3 18'h07fb2
`define FCS_DB_M4 18'h0a0c4
`define FCS_DB_M5 18'h0ca63
`define FCS_DB_M6 18'h0fecc
`define FCS_DB_M7 18'h140c5
`define FCS_DB_M8 18'h193d5
`define FCS_DB_M9 18'h1fc66
`define FCS_TEN 8'h0a
// status bit positions
`define FCS_CAL_BUSY_BIT 1
`define FCS_OPER_CAL_BIT 0
`define FCS_OPER_LLIM_BIT 11
`define FCS_STB_OPER_BIT 7
`endif

// File: hdl/fcs_power_corr.v
// power correction, averaging, limits and status hierarchy
`timescale 1ns/1ns
`include "fcs_power_corr_map.vh"
module fcs_power_corr (
  // clock and reset
  input wire i_sys_clk,
  input wire i_sys_rst,
  // detector samples and signal frequency
  input wire i_sample_valid,
  input wire [31:0] i_sample_power,
  input wire [35:0] i_sig_freq,
  // offset table
  input wire i_tbl_wr,
  input wire [6:0] i_tbl_idx,
  input wire [31:0] i_tbl_freq,
  input wire [1:0] i_tbl_scale,
  input wire [15:0] i_tbl_factor,
  input wire i_tbl_points_wr,
  input wire [6:0] i_tbl_points,
  input wire i_tbl_enable,
  input wire [6:0] i_tbl_rd_idx,
  // averaging, range and offset
  input wire i_avg_on,
  input wire i_avg_auto,
  input wire [10:0] i_average_count,
  input wire i_auto_range_switch,
  input wire i_range_sel,
  input wire i_ofs_on,
  input wire [7:0] i_channel_offset_value,
  // limits and zeroing
  input wire i_lim_on,
  input wire [31:0] i_lim_lower,
  input wire [31:0] i_lim_upper,
  input wire i_lim_clear,
  input wire i_zero_cmd,
  // status configuration and event reads
  input wire [15:0] i_cal_rising_transition_filter,
  input wire [15:0] i_cal_event_enable_mask,
  input wire i_cal_event_rd,
  input wire [15:0] i_oper_rising_transition_filter,
  input wire [15:0] i_oper_event_enable_mask,
  input wire i_oper_event_rd,
  // results
  output reg [31:0] o_result,
  output reg o_result_valid,
  output reg o_range_high,
  output reg o_limit_fail,
  output reg [15:0] o_limit_fail_counter,
  output reg [31:0] o_noise_offset,
  output reg [6:0] o_tbl_points,
  output reg [35:0] o_tbl_rd_freq,
  output reg [15:0] o_tbl_rd_factor,
  // status
  output reg [15:0] o_cal_cond,
  output reg [15:0] o_cal_event,
  output reg [15:0] o_oper_cond,
  output reg [15:0] o_oper_event,
  output reg [7:0] o_status_byte
);
  localparam ST_ACC = 4'h0;
  localparam ST_AVGDIV = 4'h1;
  localparam ST_SEARCH = 4'h2;
  localparam ST_INTDIV = 4'h3;
  localparam ST_CORRDIV = 4'h4;
  localparam ST_OFSMUL = 4'h5;
  localparam ST_OFSSTEP = 4'h6;
  localparam ST_OFSWAIT = 4'h7;
  localparam ST_CHECK = 4'h8;
  localparam ST_ZACC = 4'h9;
  localparam [47:0] RES_MAX = 48'hffff_ffff_ffff;
  localparam [47:0] RES_MAX_DIV10 = 48'h1999_9999_9999;

  // ****************************************
  // offset table storage
  // ****************************************
  // no reset on the arrays: contents survive a soft reset like stored data
  reg [35:0] tbl_f [0:`FCS_TBL_DEPTH-1];
  reg [15:0] tbl_g [0:`FCS_TBL_DEPTH-1];
  reg [29:0] scale_mult;
  wire [61:0] freq_hz = i_tbl_freq * scale_mult;
  always @* begin
    case (i_tbl_scale)
      `FCS_SCALE_HZ: scale_mult = `FCS_MULT_HZ;
      `FCS_SCALE_KHZ: scale_mult = `FCS_MULT_KHZ;
      `FCS_SCALE_MHZ: scale_mult = `FCS_MULT_MHZ;
      default: scale_mult = `FCS_MULT_GHZ;
    endcase
  end
  always @(posedge i_sys_clk) begin
    if (i_tbl_wr && i_tbl_idx <= `FCS_TBL_LAST) begin
      tbl_f[i_tbl_idx] <= freq_hz[35:0];
      tbl_g[i_tbl_idx] <= i_tbl_factor;
    end
    o_tbl_rd_freq <= tbl_f[i_tbl_rd_idx];
    o_tbl_rd_factor <= tbl_g[i_tbl_rd_idx];
  end

  // ****************************************
  // shared restoring divider
  // ****************************************
  reg [63:0] dv_n_q;
  reg [39:0] dv_d_q;
  reg dv_go_q;
  reg [63:0] dv_quo_q;
  reg [40:0] dv_rem_q;
  reg [6:0] dv_cnt_q;
  wire [40:0] dv_sh = {dv_rem_q[39:0], dv_quo_q[63]};
  wire dv_ge = dv_sh >= {1'b0, dv_d_q};
  wire dv_done = !dv_go_q && dv_cnt_q == 7'h00;
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      dv_quo_q <= 64'h0;
      dv_rem_q <= 41'h0;
      dv_cnt_q <= 7'h00;
    end else if (dv_go_q) begin
      dv_quo_q <= dv_n_q;
      dv_rem_q <= 41'h0;
      dv_cnt_q <= `FCS_DIV_STEPS;
    end else if (dv_cnt_q != 7'h00) begin
      dv_rem_q <= dv_ge ? dv_sh - {1'b0, dv_d_q} : dv_sh;
      dv_quo_q <= {dv_quo_q[62:0], dv_ge};
      dv_cnt_q <= dv_cnt_q - 7'h01;
    end
  end

  // ****************************************
  // measurement datapath helpers
  // ****************************************
  reg [3:0] st_q;
  reg [41:0] acc_q;
  reg [10:0] n_q;
  reg [10:0] tgt_q;
  reg [31:0] avg_q;
  reg [31:0] level_q;
  reg [6:0] idx_q;
  reg [15:0] gain_q;
  reg neg_q;
  reg [47:0] res_q;
  reg [3:0] left_q;
  reg lower_fail_q;
  wire [31:0] s_clean = i_sample_power > o_noise_offset ? i_sample_power - o_noise_offset : 32'h0;
  wire [6:0] last_pt = o_tbl_points - 7'h01;
  wire [6:0] nxt = idx_q + 7'h01;
  wire [15:0] g_lo = tbl_g[idx_q];
  wire [15:0] g_hi = tbl_g[nxt];
  wire [15:0] g_abs = g_hi >= g_lo ? g_hi - g_lo : g_lo - g_hi;
  wire [35:0] f_off = i_sig_freq - tbl_f[idx_q];
  wire [51:0] int_num = f_off * g_abs;
  wire [45:0] corr_num = avg_q * `FCS_UNITY_GAIN_W;
  wire [31:0] res_sat = res_q[47:32] != 16'h0 ? 32'hffff_ffff : res_q[31:0];
  // offset split into whole decades and a mantissa step
  wire ofs_neg = i_channel_offset_value[7];
  wire [7:0] ofs_mag = ofs_neg ? 8'h00 - i_channel_offset_value : i_channel_offset_value;
  wire [7:0] mag_q10 = ofs_mag / `FCS_TEN;
  wire [7:0] mag_r10 = ofs_mag % `FCS_TEN;
  wire [7:0] dec_n = (ofs_neg && mag_r10 != 8'h0) ? mag_q10 + 8'h01 : mag_q10;
  wire [7:0] mant_i = (ofs_neg && mag_r10 != 8'h0) ? `FCS_TEN - mag_r10 : mag_r10;
  reg [17:0] mant;
  always @* begin
    case (mant_i[3:0])
      4'h0: mant = `FCS_DB_M0;
      4'h1: mant = `FCS_DB_M1;
      4'h2: mant = `FCS_DB_M2;
      4'h3: mant = `FCS_DB_M3;
      4'h4: mant = `FCS_DB_M4;
      4'h5: mant = `FCS_DB_M5;
      4'h6: mant = `FCS_DB_M6;
      4'h7: mant = `FCS_DB_M7;
      4'h8: mant = `FCS_DB_M8;
      default: mant = `FCS_DB_M9;
    endcase
  end
  wire [65:0] ofs_prod = res_q * mant;
  wire [51:0] ofs_scaled = ofs_prod[65:`FCS_DB_FRAC];
  // count chosen at the first sample of each measurement
  reg [10:0] tgt_new;
  always @* begin
    tgt_new = `FCS_AVG_MIN;
    if (i_avg_on && i_avg_auto) begin
      if (level_q < `FCS_AUTO_THR_LO)
        tgt_new = `FCS_AUTO_CNT_LO;
      else if (level_q < `FCS_AUTO_THR_MID)
        tgt_new = `FCS_AUTO_CNT_MID;
      else
        tgt_new = `FCS_AUTO_CNT_HI;
    end else if (i_avg_on) begin
      if (i_average_count > `FCS_AVG_MAX)
        tgt_new = `FCS_AVG_MAX;
      else if (i_average_count != 11'h000)
        tgt_new = i_average_count;
    end
  end
  wire [10:0] tgt_now = n_q == 11'h000 ? tgt_new : tgt_q;

  // ****************************************
  // measurement state machine
  // ****************************************
  wire lim_fail_now = res_sat < i_lim_lower || res_sat > i_lim_upper;
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_q <= ST_ACC;
      acc_q <= 42'h0;
      n_q <= 11'h000;
      tgt_q <= `FCS_AVG_MIN;
      avg_q <= 32'h0;
      level_q <= 32'h0;
      idx_q <= 7'h00;
      gain_q <= `FCS_UNITY_GAIN;
      neg_q <= 1'b0;
      res_q <= 48'h0;
      left_q <= 4'h0;
      lower_fail_q <= 1'b0;
      dv_go_q <= 1'b0;
      dv_n_q <= 64'h0;
      dv_d_q <= 40'h0;
      o_result <= 32'h0;
      o_result_valid <= 1'b0;
      o_range_high <= 1'b0;
      o_limit_fail <= 1'b0;
      o_limit_fail_counter <= 16'h0;
      o_noise_offset <= 32'h0;
      o_tbl_points <= 7'h00;
    end else begin
      dv_go_q <= 1'b0;
      o_result_valid <= 1'b0;
      if (i_tbl_points_wr)
        o_tbl_points <= i_tbl_points > `FCS_TBL_LAST ? `FCS_TBL_LAST + 7'h01 : i_tbl_points;
      if (!i_auto_range_switch)
        o_range_high <= i_range_sel;
      if (i_lim_clear)
        o_limit_fail_counter <= 16'h0;
      if (i_zero_cmd) begin
        st_q <= ST_ZACC;
        acc_q <= 42'h0;
        n_q <= 11'h000;
      end else begin
        case (st_q)
          ST_ACC: if (i_sample_valid) begin
            // one sample per reading, so time grows with the count
            acc_q <= acc_q + {10'h0, s_clean};
            tgt_q <= tgt_now;
            n_q <= n_q + 11'h001;
            if (n_q + 11'h001 == tgt_now) begin
              dv_n_q <= {22'h0, acc_q + {10'h0, s_clean}};
              dv_d_q <= {29'h0, tgt_now};
              dv_go_q <= 1'b1;
              st_q <= ST_AVGDIV;
            end
          end
          ST_AVGDIV: if (dv_done) begin
            avg_q <= dv_quo_q[31:0];
            level_q <= dv_quo_q[31:0];
            acc_q <= 42'h0;
            n_q <= 11'h000;
            idx_q <= 7'h00;
            st_q <= ST_SEARCH;
          end
          ST_SEARCH: begin
            st_q <= ST_CORRDIV;
            dv_go_q <= 1'b1;
            dv_d_q <= {24'h0, tbl_g[idx_q]};
            dv_n_q <= {18'h0, corr_num};
            if (!i_tbl_enable || o_tbl_points == 7'h00) begin
              // built-in response is applied upstream; this factor stacks on it
              dv_d_q <= {24'h0, `FCS_UNITY_GAIN};
            end else if (i_sig_freq <= tbl_f[7'h00]) begin
              dv_d_q <= {24'h0, tbl_g[7'h00]};
            end else if (i_sig_freq >= tbl_f[last_pt]) begin
              dv_d_q <= {24'h0, tbl_g[last_pt]};
            end else if (tbl_f[nxt] > i_sig_freq) begin
              // relies on ascending frequencies held by the host
              dv_n_q <= {12'h0, int_num};
              dv_d_q <= {4'h0, tbl_f[nxt] - tbl_f[idx_q]};
              gain_q <= g_lo;
              neg_q <= g_hi < g_lo;
              st_q <= ST_INTDIV;
            end else begin
              dv_go_q <= 1'b0;
              idx_q <= nxt;
              st_q <= ST_SEARCH;
            end
          end
          ST_INTDIV: if (dv_done) begin
            dv_n_q <= {18'h0, corr_num};
            dv_d_q <= {24'h0, neg_q ? gain_q - dv_quo_q[15:0] : gain_q + dv_quo_q[15:0]};
            dv_go_q <= 1'b1;
            st_q <= ST_CORRDIV;
          end
          ST_CORRDIV: if (dv_done) begin
            res_q <= dv_quo_q[63:48] != 16'h0 ? RES_MAX : dv_quo_q[47:0];
            st_q <= i_ofs_on ? ST_OFSMUL : ST_CHECK;
          end
          ST_OFSMUL: begin
            res_q <= ofs_scaled[51:48] != 4'h0 ? RES_MAX : ofs_scaled[47:0];
            left_q <= dec_n[3:0];
            st_q <= ST_OFSSTEP;
          end
          ST_OFSSTEP: begin
            if (left_q == 4'h0) begin
              st_q <= ST_CHECK;
            end else if (!ofs_neg) begin
              res_q <= res_q > RES_MAX_DIV10 ? RES_MAX : (res_q << 3) + (res_q << 1);
              left_q <= left_q - 4'h1;
            end else begin
              dv_n_q <= {16'h0, res_q};
              dv_d_q <= {32'h0, `FCS_TEN};
              dv_go_q <= 1'b1;
              st_q <= ST_OFSWAIT;
            end
          end
          ST_OFSWAIT: if (dv_done) begin
            res_q <= dv_quo_q[47:0];
            left_q <= left_q - 4'h1;
            st_q <= ST_OFSSTEP;
          end
          ST_CHECK: begin
            o_result <= res_sat;
            o_result_valid <= 1'b1;
            if (i_auto_range_switch)
              o_range_high <= res_sat >= `FCS_RANGE_THR;
            if (i_lim_on) begin
              o_limit_fail <= lim_fail_now;
              lower_fail_q <= res_sat < i_lim_lower;
              if (lim_fail_now && (o_limit_fail_counter != 16'hffff || i_lim_clear))
                o_limit_fail_counter <= i_lim_clear ? 16'h1 : o_limit_fail_counter + 16'h1;
            end else begin
              o_limit_fail <= 1'b0;
              lower_fail_q <= 1'b0;
            end
            st_q <= ST_ACC;
          end
          ST_ZACC: if (i_sample_valid) begin
            acc_q <= acc_q + {10'h0, i_sample_power};
            n_q <= n_q + 11'h001;
            if (n_q[4:0] + 5'h01 == `FCS_ZERO_SAMPLES) begin
              o_noise_offset <= acc_q[35:4] + (i_sample_power >> `FCS_ZERO_SHIFT);
              acc_q <= 42'h0;
              n_q <= 11'h000;
              st_q <= ST_ACC;
            end
          end
          default: st_q <= ST_ACC;
        endcase
      end
    end
  end

  // ****************************************
  // status hierarchy
  // ****************************************
  reg [15:0] cal_cond_d;
  reg [15:0] oper_cond_d;
  always @* begin
    cal_cond_d = 16'h0;
    cal_cond_d[`FCS_CAL_BUSY_BIT] = st_q == ST_ZACC || i_zero_cmd;
    oper_cond_d = 16'h0;
    oper_cond_d[`FCS_OPER_CAL_BIT] = |(o_cal_event & i_cal_event_enable_mask);
    oper_cond_d[`FCS_OPER_LLIM_BIT] = lower_fail_q;
  end
  wire [15:0] cal_rise = cal_cond_d & ~o_cal_cond & i_cal_rising_transition_filter;
  wire [15:0] oper_rise = oper_cond_d & ~o_oper_cond & i_oper_rising_transition_filter;
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_cal_cond <= 16'h0;
      o_cal_event <= 16'h0;
      o_oper_cond <= 16'h0;
      o_oper_event <= 16'h0;
      o_status_byte <= 8'h00;
    end else begin
      o_cal_cond <= cal_cond_d;
      o_oper_cond <= oper_cond_d;
      // a new event in the read cycle survives the clear
      o_cal_event <= (i_cal_event_rd ? 16'h0 : o_cal_event) | cal_rise;
      o_oper_event <= (i_oper_event_rd ? 16'h0 : o_oper_event) | oper_rise;
      o_status_byte <= 8'h00;
      o_status_byte[`FCS_STB_OPER_BIT] <= |(o_oper_event & i_oper_event_enable_mask);
    end
  end
endmodule // fcs_power_corr

// File: verif/fcs_power_corr_monitor.sv
// concurrent checks on the power correction block ports
`timescale 1ns/1ns
module fcs_power_corr_monitor (
  // clock and reset
  input wire i_sys_clk,
  input wire i_sys_rst,
  // watched inputs
  input wire i_zero_cmd,
  input wire i_lim_clear,
  input wire i_auto_range_switch,
  input wire i_range_sel,
  input wire [15:0] i_cal_rising_transition_filter,
  input wire [15:0] i_cal_event_enable_mask,
  input wire [15:0] i_oper_event_enable_mask,
  // watched outputs
  input wire o_result_valid,
  input wire o_range_high,
  input wire o_limit_fail,
  input wire [15:0] o_limit_fail_counter,
  input wire [15:0] o_cal_cond,
  input wire [15:0] o_cal_event,
  input wire [15:0] o_oper_cond,
  input wire [15:0] o_oper_event,
  input wire [7:0] o_status_byte
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // ***************
  // status hierarchy
  // ***************
  zero_busy_a: assert property (i_zero_cmd |=> o_cal_cond[1])
    else $error("calibrating bit not raised by zeroing");
  cal_event_a: assert property ($rose(o_cal_cond[1]) && i_cal_rising_transition_filter[1]
    |-> ##[0:1] o_cal_event[1])
    else $error("calibration event not latched");
  oper_cal_a: assert property (|(o_cal_event & i_cal_event_enable_mask) |=> o_oper_cond[0])
    else $error("operation calibration summary missing");
  stb_oper_a: assert property (|(o_oper_event & i_oper_event_enable_mask)
    |=> o_status_byte[7])
    else $error("status byte summary missing");
  stb_rest_a: assert property (o_status_byte[6:0] == 7'h00)
    else $error("unused status byte bits set");
  // ***************
  // results, range and limits
  // ***************
  valid_pulse_a: assert property (o_result_valid |=> !o_result_valid)
    else $error("result valid longer than one cycle");
  range_man_a: assert property (!$past(i_auto_range_switch) && !i_auto_range_switch
    |-> o_range_high == $past(i_range_sel))
    else $error("manual range not followed");
  fail_step_a: assert property (!$past(i_lim_clear) && $changed(o_limit_fail_counter)
    |-> o_limit_fail_counter == $past(o_limit_fail_counter) + 16'h0001)
    else $error("failure counter stepped wrongly");
  low_lim_a: assert property (o_oper_cond[11] |-> $past(o_limit_fail))
    else $error("lower limit condition without failure");
endmodule // fcs_power_corr_monitor

bind fcs_power_corr fcs_power_corr_monitor mon_u (.i_sys_clk, .i_sys_rst, .i_zero_cmd,
  .i_lim_clear, .i_auto_range_switch, .i_range_sel, .i_cal_rising_transition_filter,
  .i_cal_event_enable_mask, .i_oper_event_enable_mask, .o_result_valid, .o_range_high,
  .o_limit_fail, .o_limit_fail_counter, .o_cal_cond, .o_cal_event, .o_oper_cond,
  .o_oper_event, .o_status_byte);

// File: verif/fcs_host_model.sv
// far-side model that hands detector readings to the block
`timescale 1ns/1ns
module fcs_host_model (
  // clock
  input wire logic i_sys_clk,
  // reading to the block
  output logic o_sample_valid,
  output logic [31:0] o_sample_power
);
  initial begin
    o_sample_valid = 1'b0;
    o_sample_power = 32'h0;
  end
  // one reading held for exactly one sampling edge
  task automatic send(input logic [31:0] p);
    @(posedge i_sys_clk);
    #1;
    o_sample_valid = 1'b1;
    o_sample_power = p;
    @(posedge i_sys_clk);
    #1;
    o_sample_valid = 1'b0;
    // released lines show the inverse so stale data cannot pass
    o_sample_power = ~p;
  endtask
endmodule // fcs_host_model

// File: verif/fcs_power_corr_tb.sv
// self-checking bench for the power correction block
`timescale 1ns/1ns
module fcs_power_corr_tb;
  // ***************
  // signals
  // ***************
  logic i_sys_clk = 0, i_sys_rst = 1, i_sample_valid, i_tbl_wr = 0, i_tbl_points_wr = 0;
  logic i_tbl_enable = 0, i_avg_on = 0, i_avg_auto = 0, i_auto_range_switch = 0;
  logic i_range_sel = 0, i_ofs_on = 0, i_lim_on = 0, i_lim_clear = 0, i_zero_cmd = 0;
  logic i_cal_event_rd = 0, i_oper_event_rd = 0, o_result_valid, o_range_high, o_limit_fail;
  logic [31:0] i_sample_power, i_tbl_freq = 0, i_lim_lower = 0, i_lim_upper = 0;
  logic [31:0] o_result, o_noise_offset;
  logic [35:0] i_sig_freq = 0, o_tbl_rd_freq;
  logic [6:0] i_tbl_idx = 0, i_tbl_points = 0, i_tbl_rd_idx = 0, o_tbl_points;
  logic [1:0] i_tbl_scale = 0;
  logic [15:0] i_tbl_factor = 0, i_cal_rising_transition_filter = 0;
  logic [15:0] i_cal_event_enable_mask = 0, i_oper_rising_transition_filter = 0;
  logic [15:0] i_oper_event_enable_mask = 0, o_limit_fail_counter, o_tbl_rd_factor;
  logic [15:0] o_cal_cond, o_cal_event, o_oper_cond, o_oper_event;
  logic [10:0] i_average_count = 1;
  logic [7:0] i_channel_offset_value = 0, o_status_byte;
  int fail_count = 0, compares = 0;
  fcs_power_corr dut_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_sample_valid(i_sample_valid), .i_sample_power(i_sample_power),
    .i_sig_freq(i_sig_freq), .i_tbl_wr(i_tbl_wr), .i_tbl_idx(i_tbl_idx),
    .i_tbl_freq(i_tbl_freq), .i_tbl_scale(i_tbl_scale), .i_tbl_factor(i_tbl_factor),
    .i_tbl_points_wr(i_tbl_points_wr), .i_tbl_points(i_tbl_points),
    .i_tbl_enable(i_tbl_enable), .i_tbl_rd_idx(i_tbl_rd_idx), .i_avg_on(i_avg_on),
    .i_avg_auto(i_avg_auto), .i_average_count(i_average_count),
    .i_auto_range_switch(i_auto_range_switch), .i_range_sel(i_range_sel),
    .i_ofs_on(i_ofs_on), .i_channel_offset_value(i_channel_offset_value),
    .i_lim_on(i_lim_on), .i_lim_lower(i_lim_lower), .i_lim_upper(i_lim_upper),
    .i_lim_clear(i_lim_clear), .i_zero_cmd(i_zero_cmd),
    .i_cal_rising_transition_filter(i_cal_rising_transition_filter),
    .i_cal_event_enable_mask(i_cal_event_enable_mask), .i_cal_event_rd(i_cal_event_rd),
    .i_oper_rising_transition_filter(i_oper_rising_transition_filter),
    .i_oper_event_enable_mask(i_oper_event_enable_mask), .i_oper_event_rd(i_oper_event_rd),
    .o_result(o_result), .o_result_valid(o_result_valid), .o_range_high(o_range_high),
    .o_limit_fail(o_limit_fail), .o_limit_fail_counter(o_limit_fail_counter),
    .o_noise_offset(o_noise_offset), .o_tbl_points(o_tbl_points),
    .o_tbl_rd_freq(o_tbl_rd_freq), .o_tbl_rd_factor(o_tbl_rd_factor),
    .o_cal_cond(o_cal_cond), .o_cal_event(o_cal_event), .o_oper_cond(o_oper_cond),
    .o_oper_event(o_oper_event), .o_status_byte(o_status_byte));
  fcs_host_model host_u (.i_sys_clk(i_sys_clk), .o_sample_valid(i_sample_valid),
    .o_sample_power(i_sample_power));
  always #5 i_sys_clk = ~i_sys_clk;
  // ***************
  // shared tasks
  // ***************
  task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic measure(input logic [31:0] p, input logic [31:0] exp);
    int k;
    host_u.send(p);
    for (k = 0; k < 3000 && o_result_valid !== 1'b1; k++) tick(1);
    chk("result_valid", 1, o_result_valid);
    chk("result", {4'h0, exp}, {4'h0, o_result});
  endtask
  task automatic wr_tbl(input int i, input int f, input int s, input int g);
    i_tbl_idx = i[6:0];
    i_tbl_freq = f[31:0];
    i_tbl_scale = s[1:0];
    i_tbl_factor = g[15:0];
    i_tbl_wr = 1;
    tick(1);
    i_tbl_wr = 0;
    tick(1);
  endtask
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ***************
  // scenarios
  // ***************
  task automatic test_reset();
    chk("result", 0, o_result);
    chk("fail_counter", 0, o_limit_fail_counter);
    chk("status_byte", 0, o_status_byte);
    measure(32'd3000, 32'd3000);
  endtask
  task automatic test_table();
    wr_tbl(0, 1000, 1, 10000);
    wr_tbl(1, 3, 2, 5000);
    wr_tbl(2, 1, 3, 5000);
    wr_tbl(3, 7, 0, 5000);
    i_tbl_points = 7'h02;
    i_tbl_points_wr = 1;
    tick(1);
    i_tbl_points_wr = 0;
    tick(1);
    chk("points", 2, o_tbl_points);
    i_tbl_rd_idx = 7'h02;
    tick(2);
    chk("freq_ghz", 36'h03b9aca00, o_tbl_rd_freq);
    chk("factor_rd", 5000, o_tbl_rd_factor);
    i_tbl_rd_idx = 7'h03;
    tick(2);
    chk("freq_hz", 36'h7, o_tbl_rd_freq);
    i_tbl_rd_idx = 7'h00;
    tick(2);
    chk("freq_khz", 36'hf4240, o_tbl_rd_freq);
    i_tbl_enable = 1;
    i_sig_freq = 36'd500000;
    measure(32'd3000, 32'd3000);
    i_sig_freq = 36'd2000000;
    measure(32'd3000, 32'd4000);
    i_sig_freq = 36'd5000000;
    measure(32'd3000, 32'd6000);
    i_tbl_enable = 0;
    measure(32'd3000, 32'd3000);
  endtask
  task automatic test_range();
    i_range_sel = 1;
    tick(2);
    chk("range_man", 1, o_range_high);
    i_auto_range_switch = 1;
    measure(32'h0100_0000, 32'h0100_0000);
    tick(2);
    chk("range_auto_hi", 1, o_range_high);
    measure(32'h10, 32'h10);
    tick(2);
    chk("range_auto_lo", 0, o_range_high);
    i_auto_range_switch = 0;
    i_range_sel = 0;
  endtask
  task automatic test_offset();
    i_ofs_on = 1;
    i_channel_offset_value = 8'h0a;
    measure(32'd3000, 32'd30000);
    i_channel_offset_value = 8'hf6;
    measure(32'd3000, 32'd300);
    i_ofs_on = 0;
  endtask
  task automatic test_average();
    i_avg_on = 1;
    i_average_count = 11'h004;
    host_u.send(32'd100);
    host_u.send(32'd200);
    host_u.send(32'd300);
    measure(32'd400, 32'd250);
    i_avg_on = 0;
    measure(32'h0100_0000, 32'h0100_0000);
    i_avg_on = 1;
    i_avg_auto = 1;
    repeat (15) host_u.send(32'h0100_0000);
    measure(32'h0110_0000, 32'h0101_0000);
    i_avg_on = 0;
    i_avg_auto = 0;
  endtask
  task automatic test_limits();
    i_lim_on = 1;
    i_lim_lower = 32'd5000;
    i_lim_upper = 32'd10000;
    i_oper_rising_transition_filter = 16'h0800;
    i_oper_event_enable_mask = 16'h0800;
    measure(32'd3000, 32'd3000);
    chk("fail_low", 1, o_limit_fail);
    tick(4);
    chk("oper_cond", 36'h800, o_oper_cond);
    chk("stb_limit", 36'h80, o_status_byte);
    measure(32'd7000, 32'd7000);
    chk("pass", 0, o_limit_fail);
    measure(32'd20000, 32'd20000);
    chk("fail_high", 1, o_limit_fail);
    chk("fail_counter", 2, o_limit_fail_counter);
    i_oper_event_rd = 1;
    tick(1);
    i_oper_event_rd = 0;
    tick(1);
    chk("oper_event_rd", 0, o_oper_event);
    i_lim_clear = 1;
    tick(1);
    i_lim_clear = 0;
    tick(1);
    chk("fail_clear", 0, o_limit_fail_counter);
    i_lim_on = 0;
  endtask
  task automatic test_zero();
    int n;
    i_cal_rising_transition_filter = 16'h0002;
    i_cal_event_enable_mask = 16'h0002;
    i_oper_rising_transition_filter = 16'h0001;
    i_oper_event_enable_mask = 16'h0001;
    i_zero_cmd = 1;
    tick(1);
    i_zero_cmd = 0;
    tick(8);
    chk("cal_cond", 36'h2, o_cal_cond);
    chk("cal_event", 36'h2, o_cal_event);
    chk("oper_cal", 1, o_oper_cond[0]);
    chk("stb_cal", 36'h80, o_status_byte);
    for (n = 0; n < 16; n++) host_u.send(32'd32);
    tick(2);
    chk("noise", 36'd32, o_noise_offset);
    chk("cal_done", 0, o_cal_cond);
    i_cal_event_rd = 1;
    tick(1);
    i_cal_event_rd = 0;
    tick(1);
    chk("cal_event_rd", 0, o_cal_event);
    measure(32'd1032, 32'd1000);
  endtask
  // ***************
  // main sequence and watchdog
  // ***************
  initial begin
    repeat (20) @(posedge i_sys_clk);
    #1;
    i_sys_rst = 0;
    tick(1);
    test_reset();
    test_table();
    test_range();
    test_offset();
    test_average();
    test_limits();
    test_zero();
    end_of_test();
  end
  initial begin
    #300000;
    fail_count++;
    end_of_test();
  end
endmodule // fcs_power_corr_tb
